// ===== tmg_pkg.sv
package tmg_pkg;

  // Register byte addresses on the APB slave.
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_GATE_CONTROL  = 8'h04;
  localparam logic [7:0] ADDR_COUNT_LOW     = 8'h08;
  localparam logic [7:0] ADDR_COUNT_HIGH    = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK      = 8'h14;
  localparam logic [7:0] ADDR_COMPANION     = 8'h18;

  // Bit positions inside timer_control.
  localparam int TC_TIMER_ON = 0;

  // Bit positions inside gate_control.
  localparam int GC_ENABLE   = 7;
  localparam int GC_POLARITY = 6;
  localparam int GC_TOGGLE   = 5;
  localparam int GC_SINGLE   = 4;
  localparam int GC_GO       = 3;
  localparam int GC_VALUE    = 2;
  localparam int GC_SEL_HI   = 1;
  localparam int GC_SEL_LO   = 0;

  // Bit positions inside irq_status and irq_mask.
  localparam int IRQ_GATE_EVENT = 0;
  localparam int IRQ_ROLLOVER   = 1;

  // Gate source select codes.
  localparam logic [1:0] SEL_PIN      = 2'h0;
  localparam logic [1:0] SEL_OVERFLOW = 2'h1;

  // Reset values and widths.
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [15:0] COUNT_ZERO  = 16'h0000;
  localparam logic [15:0] COUNT_ONE   = 16'h0001;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;
  localparam logic [7:0]  COMP_ONE    = 8'h01;
  localparam logic [7:0]  COMP_MAX    = 8'hff;
  localparam logic [1:0]  IRQ_ZERO    = 2'h0;

endpackage : tmg_pkg

// ===== tmg_gate_if.sv
`timescale 1ns/10ps
interface tmg_gate_if;
  logic       timer_on;
  logic       gate_polarity;
  logic       gate_toggle_mode;
  logic       gate_single_pulse_mode;
  logic       pulse_acquire_go;
  logic [1:0] gate_source_select;
  logic       gate_input_pin;
  logic       overflow_pulse;
  logic       gate_current_value;
  logic       gate_fall;
  logic       go_done;

  modport ctrl (
    output timer_on, gate_polarity, gate_toggle_mode,
    output gate_single_pulse_mode, pulse_acquire_go, gate_source_select,
    output gate_input_pin, overflow_pulse,
    input  gate_current_value, gate_fall, go_done
  );
  modport gate (
    input  timer_on, gate_polarity, gate_toggle_mode,
    input  gate_single_pulse_mode, pulse_acquire_go, gate_source_select,
    input  gate_input_pin, overflow_pulse,
    output gate_current_value, gate_fall, go_done
  );
endinterface : tmg_gate_if

// ===== tmg_companion_timer.sv
`timescale 1ns/10ps
module tmg_companion_timer (
  // Clock and reset.
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // Count tick and results.
  input  wire logic       i_tick,
  output logic [7:0]      o_count,
  output logic            o_overflow
);

  typedef struct packed {
    logic [7:0] count;
    logic       overflow;
  } tmg_comp_state_t;

  tmg_comp_state_t state_reg;
  tmg_comp_state_t state_next;

  // The overflow pulse is high for one cycle after the count wraps to zero.
  always_comb
  begin
    state_next          = state_reg;
    state_next.overflow = 1'b0;
    if (i_tick)
    begin
      state_next.count    = state_reg.count + tmg_pkg::COMP_ONE;
      state_next.overflow = (state_reg.count == tmg_pkg::COMP_MAX);
    end
  end

  // State register.
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign o_count    = state_reg.count;
  assign o_overflow = state_reg.overflow;

endmodule : tmg_companion_timer

// ===== tmg_gate_path.sv
`timescale 1ns/10ps
module tmg_gate_path (
  // Clock and reset.
  input  wire logic i_clock,
  input  wire logic i_rst,
  // Control and results.
  tmg_gate_if.gate  gate_bus
);

  typedef struct packed {
    logic polar_prev;
    logic toggle_ff;
    logic stage_prev;
    logic window;
    logic value;
    logic fall;
    logic done;
  } tmg_gate_state_t;

  tmg_gate_state_t state_reg;
  tmg_gate_state_t state_next;
  logic            source;
  logic            polar;
  logic            stage;
  logic            gate;

  // Source, polarity, toggle, then the single-pulse window, in that order.
  always_comb
  begin
    state_next      = state_reg;
    state_next.fall = 1'b0;
    state_next.done = 1'b0;
    case (gate_bus.gate_source_select)
      tmg_pkg::SEL_PIN:      source = gate_bus.gate_input_pin;
      tmg_pkg::SEL_OVERFLOW: source = gate_bus.overflow_pulse;
      default:               source = 1'b0;
    endcase
    // Polarity turns the source into an active-high count request.
    polar = gate_bus.gate_polarity ? source : ~source;
    state_next.polar_prev = polar;
    // The flip-flop is held clear outside toggle mode or with the timer off.
    if (!gate_bus.gate_toggle_mode || !gate_bus.timer_on)
      state_next.toggle_ff = 1'b0;
    else if (polar && !state_reg.polar_prev)
      state_next.toggle_ff = ~state_reg.toggle_ff;
    stage = gate_bus.gate_toggle_mode ? state_reg.toggle_ff : polar;
    state_next.stage_prev = stage;
    // Window opens on a leading edge while armed, closes on the trailing one.
    if (!gate_bus.gate_single_pulse_mode)
      state_next.window = 1'b0;
    else if (state_reg.window && !stage && state_reg.stage_prev)
    begin
      state_next.window = 1'b0;
      state_next.done   = 1'b1;
    end
    else if (gate_bus.pulse_acquire_go && stage && !state_reg.stage_prev)
      state_next.window = 1'b1;
    gate = gate_bus.gate_single_pulse_mode ?
           (state_reg.window && stage) : stage;
    state_next.value = gate;
    state_next.fall  = state_reg.value && !gate;
  end

  // State register; the gate value settles one cycle after reset.
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign gate_bus.gate_current_value = state_reg.value;
  assign gate_bus.gate_fall          = state_reg.fall;
  assign gate_bus.go_done            = state_reg.done;

endmodule : tmg_gate_path

// ===== tmg_timer_gate.sv
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
// Summary of operation
// - Gate enable matters only with timer on; clear enable counts freely.
// - Polarity one counts while gate high; zero counts while gate low.
// - Toggle mode routes gate through flip-flop; off holds it clear.
// - Toggle flip-flop flips on every leading edge of the gate.
// - Single-pulse mode lets the acquisition window control the gate.
// - Go bit reads one while armed; software sets, hardware clears it.
// - Gate value bit shows gate as counter sees it, whatever enable says.
// - Source select 00 picks pin, 01 companion overflow, others reserved.
// - Writable control bits reset to zero on power-on reset.
// - Count readable and writable as high and low bytes.
// - Armed pulse counts from leading edge; trailing edge ends and disarms.
// - Falling gate value sets event flag; enable raises interrupt.
// - Companion timer wrap from maximum to zero gives overflow pulse.
// - Clearing timer on stops counting and clears toggle flip-flop.
module tmg_timer_gate (
  // Clock and reset.
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // APB slave.
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Timer clock ticks and gate pin.
  input  wire logic        i_count_tick,
  input  wire logic        i_companion_tick,
  input  wire logic        i_gate_input_pin,
  // Interrupt and live gate.
  output logic             o_irq,
  output logic             o_count_enable
);

  typedef struct packed {
    logic        timer_on;
    logic [7:0]  gate_control;
    logic [15:0] count;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        count_enable;
  } tmg_top_state_t;

  tmg_top_state_t state_reg;
  tmg_top_state_t state_next;
  logic [7:0]     comp_count;
  logic           comp_overflow;
  logic           access;
  logic           done;
  logic           wr;
  logic           rd;
  logic           mapped;
  logic [7:0]     rd_byte;
  logic [1:0]     events;
  logic [7:0]     gc_view;

  tmg_gate_if gate_bus ();

  // Companion 8-bit timer that provides the overflow gate source.
  tmg_companion_timer u_companion (
    .i_clock    (i_clock),
    .i_rst      (i_rst),
    .i_tick     (i_companion_tick),
    .o_count    (comp_count),
    .o_overflow (comp_overflow)
  );

  // Gate conditioning path.
  tmg_gate_path u_gate (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .gate_bus (gate_bus)
  );

  // Control fields feed the gate path straight from their registers.
  assign gate_bus.timer_on               = state_reg.timer_on;
  assign gate_bus.gate_polarity          =
    state_reg.gate_control[tmg_pkg::GC_POLARITY];
  assign gate_bus.gate_toggle_mode       =
    state_reg.gate_control[tmg_pkg::GC_TOGGLE];
  assign gate_bus.gate_single_pulse_mode =
    state_reg.gate_control[tmg_pkg::GC_SINGLE];
  assign gate_bus.pulse_acquire_go       =
    state_reg.gate_control[tmg_pkg::GC_GO];
  assign gate_bus.gate_source_select     =
    state_reg.gate_control[tmg_pkg::GC_SEL_HI:tmg_pkg::GC_SEL_LO];
  assign gate_bus.gate_input_pin         = i_gate_input_pin;
  assign gate_bus.overflow_pulse         = comp_overflow;

  // Read view of gate_control with the live value bit spliced in.
  always_comb
  begin
    gc_view = state_reg.gate_control;
    gc_view[tmg_pkg::GC_VALUE] = gate_bus.gate_current_value;
  end

  // Address decode; a transfer finishes on the edge where pready is high.
  always_comb
  begin
    access = i_psel && i_penable;
    done   = access && state_reg.pready;
    wr     = done && i_pwrite && !state_reg.pslverr;
    rd     = done && !i_pwrite && !state_reg.pslverr;
    mapped = 1'b1;
    case (i_paddr)
      tmg_pkg::ADDR_TIMER_CONTROL:
        rd_byte = {7'h00, state_reg.timer_on};
      tmg_pkg::ADDR_GATE_CONTROL:
        rd_byte = gc_view;
      tmg_pkg::ADDR_COUNT_LOW:
        rd_byte = state_reg.count[7:0];
      tmg_pkg::ADDR_COUNT_HIGH:
        rd_byte = state_reg.count[15:8];
      tmg_pkg::ADDR_IRQ_STATUS:
        rd_byte = {6'h00, state_reg.irq_status};
      tmg_pkg::ADDR_IRQ_MASK:
        rd_byte = {6'h00, state_reg.irq_mask};
      tmg_pkg::ADDR_COMPANION:
        rd_byte = comp_count;
      default:
      begin
        rd_byte = tmg_pkg::BYTE_ZERO;
        mapped  = 1'b0;
      end
    endcase
  end

  // Register file, counter and interrupt logic.
  always_comb
  begin
    state_next = state_reg;
    // Bus answer: one wait state, data captured as pready rises.
    state_next.pready  = access && !state_reg.pready;
    state_next.pslverr = access && !state_reg.pready && !mapped;
    if (access && !state_reg.pready)
      state_next.prdata = {24'h000000, rd_byte};
    else
      state_next.prdata = 32'h00000000;
    // Software writes.
    if (wr && i_paddr == tmg_pkg::ADDR_TIMER_CONTROL)
      state_next.timer_on = i_pwdata[tmg_pkg::TC_TIMER_ON];
    if (wr && i_paddr == tmg_pkg::ADDR_GATE_CONTROL)
    begin
      state_next.gate_control = i_pwdata[7:0];
      state_next.gate_control[tmg_pkg::GC_VALUE] = 1'b0;
    end
    else if (gate_bus.go_done)
      state_next.gate_control[tmg_pkg::GC_GO] = 1'b0;
    if (wr && i_paddr == tmg_pkg::ADDR_IRQ_MASK)
      state_next.irq_mask = i_pwdata[1:0];
    // Count enable: gate matters only with the timer on and gate enabled.
    state_next.count_enable = state_next.timer_on &&
      (!state_next.gate_control[tmg_pkg::GC_ENABLE] ||
       gate_bus.gate_current_value);
    events = tmg_pkg::IRQ_ZERO;
    if (wr && i_paddr == tmg_pkg::ADDR_COUNT_LOW)
      state_next.count[7:0] = i_pwdata[7:0];
    else if (wr && i_paddr == tmg_pkg::ADDR_COUNT_HIGH)
      state_next.count[15:8] = i_pwdata[7:0];
    else if (i_count_tick && state_reg.count_enable)
    begin
      state_next.count = state_reg.count + tmg_pkg::COUNT_ONE;
      events[tmg_pkg::IRQ_ROLLOVER] = (state_reg.count == tmg_pkg::COUNT_MAX);
    end
    events[tmg_pkg::IRQ_GATE_EVENT] = gate_bus.gate_fall;
    // Status clears on read, but a new event in that cycle still lands.
    if (rd && i_paddr == tmg_pkg::ADDR_IRQ_STATUS)
      state_next.irq_status = events;
    else
      state_next.irq_status = state_reg.irq_status | events;
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);
  end

  // State register; power-on reset clears all the control bits.
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      state_reg              <= '0;
      state_reg.count        <= tmg_pkg::COUNT_ZERO;
    end
    else
      state_reg <= state_next;
  end

  assign o_prdata       = state_reg.prdata;
  assign o_pready       = state_reg.pready;
  assign o_pslverr      = state_reg.pslverr;
  assign o_irq          = state_reg.irq;
  assign o_count_enable = state_reg.count_enable;

endmodule : tmg_timer_gate

// ===== tmg_timer_gate_asserts.sv
`timescale 1ns/10ps
module tmg_timer_gate_asserts (
  // Clock and reset.
  input wire logic        i_clock,
  input wire logic        i_rst,
  // APB slave.
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // Ticks, pin, interrupt and live gate.
  input wire logic        i_count_tick,
  input wire logic        i_companion_tick,
  input wire logic        i_gate_input_pin,
  input wire logic        o_irq,
  input wire logic        o_count_enable
);
  logic       on_reg;
  logic [7:0] gc_reg;
  logic [1:0] mk_reg;
  logic [1:0] age_reg;
  logic       wr_ok;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Mirror control writes; gate checks wait until the setup has settled.
  assign wr_ok = i_psel && i_penable && o_pready && i_pwrite;
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      on_reg  <= 1'b0;
      gc_reg  <= 8'h00;
      mk_reg  <= 2'h0;
      age_reg <= 2'h3;
    end
    else
    begin
      age_reg <= (wr_ok && i_paddr < 8'h08) ? 2'h0 :
                 (age_reg == 2'h3) ? 2'h3 : age_reg + 2'h1;
      if (wr_ok && i_paddr == tmg_pkg::ADDR_TIMER_CONTROL)
        on_reg <= i_pwdata[tmg_pkg::TC_TIMER_ON];
      if (wr_ok && i_paddr == tmg_pkg::ADDR_GATE_CONTROL)
        gc_reg <= i_pwdata[7:0];
      if (wr_ok && i_paddr == tmg_pkg::ADDR_IRQ_MASK)
        mk_reg <= i_pwdata[1:0];
    end
  end
  sequence s_access;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_settled;
    age_reg == 2'h3;
  endsequence
  a_ready_time: assert property (s_access |=> o_pready)
    else $error("pready did not follow the access cycle");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready held longer than one cycle");
  a_err_unmapped: assert property (o_pready |-> o_pslverr ==
    (i_paddr > 8'h18 || i_paddr[1:0] != 2'h0))
    else $error("pslverr does not match the address");
  a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside an answer");
  a_off_no_count: assert property (s_settled ##0 !on_reg
    |-> !o_count_enable)
    else $error("count enabled with timer off");
  a_free_count: assert property (s_settled ##0 (on_reg && !gc_reg[7])
    |-> o_count_enable)
    else $error("ungated timer not counting");
  a_gate_polarity: assert property (s_settled ##0 (on_reg &&
    gc_reg[7] && gc_reg[5:4] == 2'h0 && gc_reg[1:0] == tmg_pkg::SEL_PIN)
    |-> o_count_enable == ($past(i_gate_input_pin, 2) == gc_reg[6]))
    else $error("gate polarity wrong");
  a_irq_masked: assert property (mk_reg == 2'h0 &&
    $past(mk_reg) == 2'h0 |-> !o_irq)
    else $error("interrupt raised while masked");
endmodule : tmg_timer_gate_asserts

bind tmg_timer_gate tmg_timer_gate_asserts chk_u (
  .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_count_tick(i_count_tick),
  .i_companion_tick(i_companion_tick), .o_irq(o_irq),
  .i_gate_input_pin(i_gate_input_pin), .o_count_enable(o_count_enable)
);

// ===== tmg_gate_partner.sv
`timescale 1ns/10ps
module tmg_gate_partner (
  // Clock.
  input wire logic i_clock,
  // Gate pin and companion timer tick.
  output logic     o_gate_input_pin,
  output logic     o_companion_tick
);
  // Pin starts high so the active-low reset setup shows a quiet gate.
  initial
  begin
    o_gate_input_pin = 1'b1;
    o_companion_tick = 1'b0;
  end
  // Pin level changes only just after a clock edge.
  task set_pin(input logic v);
    o_gate_input_pin <= v;
  endtask : set_pin
  // Back-to-back companion ticks, one per cycle.
  task burst(input int n);
    for (int k = 0; k <= n; k++)
    begin
      o_companion_tick <= (k < n);
      if (k < n)
        @(posedge i_clock);
    end
  endtask : burst
  // A pulse, then low long enough for the gate path to settle.
  task pulse(input int n);
    o_gate_input_pin <= 1'b1;
    repeat (n) @(posedge i_clock);
    o_gate_input_pin <= 1'b0;
    repeat (4) @(posedge i_clock);
  endtask : pulse
endmodule : tmg_gate_partner

// ===== test_timer_gate_control.sv
`timescale 1ns/10ps
`define CHK(n, e, a) \
  begin \
    compares++; \
    if ((a) !== (e)) \
    begin \
      err_count++; \
      $display("CHECK FAILED %s exp %h got %h", n, e, a); \
    end \
  end
module test_timer_gate_control;
  logic        i_clock, i_rst, i_psel, i_penable, i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, rdata;
  logic        o_pready, o_pslverr, slverr, o_irq, o_count_enable;
  logic        i_count_tick, i_companion_tick, i_gate_input_pin, m_tog;
  logic [15:0] cnt;
  logic [7:0]  rnd;
  int          err_count, compares, m_cnt;
  tmg_timer_gate dut_u (
    .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_count_tick(i_count_tick),
    .i_companion_tick(i_companion_tick), .o_irq(o_irq),
    .i_gate_input_pin(i_gate_input_pin), .o_count_enable(o_count_enable)
  );
  tmg_gate_partner far_u (
    .i_clock(i_clock), .o_gate_input_pin(i_gate_input_pin),
    .o_companion_tick(i_companion_tick)
  );
  // Free-running 50 MHz clock.
  initial
  begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // One APB transfer; the request stands until pready is seen high.
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {24'h000000, d};
    @(posedge i_clock);
    i_penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (o_pready !== 1'b1 && n < 16);
    `CHK("pready", 1'b1, o_pready)
    rdata = o_prdata;
    slverr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clock);
  endtask : apb
  task rd(input string s, input logic [7:0] a, input logic [8:0] e);
    logic [8:0] got;
    apb(1'b0, a, 8'h00);
    got = {slverr, rdata[7:0]};
    `CHK(s, e, got)
  endtask : rd
  task wgc(input logic [7:0] d);
    apb(1'b1, tmg_pkg::ADDR_GATE_CONTROL, d);
  endtask : wgc
  task rgc(input string s, input logic [7:0] e);
    rd(s, tmg_pkg::ADDR_GATE_CONTROL, {1'b0, e});
  endtask : rgc
  // Count is read as two bytes while no ticks arrive, so no tearing.
  task rdc(output logic [15:0] c);
    apb(1'b0, tmg_pkg::ADDR_COUNT_LOW, 8'h00);
    c[7:0] = rdata[7:0];
    apb(1'b0, tmg_pkg::ADDR_COUNT_HIGH, 8'h00);
    c[15:8] = rdata[7:0];
  endtask : rdc
  task clr_cnt;
    apb(1'b1, tmg_pkg::ADDR_COUNT_LOW, 8'h00);
    apb(1'b1, tmg_pkg::ADDR_COUNT_HIGH, 8'h00);
  endtask : clr_cnt
  // The tick stands for n edges, then one quiet edge follows.
  task tk(input int n);
    for (int k = 0; k <= n; k++)
    begin
      i_count_tick <= (k < n);
      @(posedge i_clock);
    end
  endtask : tk
  task stop_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  // Hang guard, well beyond the thousand or so cycles the run needs.
  initial
  begin
    #400000;
    err_count++;
    stop_test();
  end
  // Main sequence.
  initial
  begin
    {i_rst, i_psel, i_penable, i_pwrite, i_count_tick} = 5'h10;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    rnd = 8'h46;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    for (int a = 0; a < 28; a += 4)
      rd("reset", a[7:0], 9'h000);
    rd("unmapped", 8'h1c, 9'h100);
    rnd = lfsr(rnd);
    apb(1'b1, tmg_pkg::ADDR_COUNT_LOW, rnd);
    m_cnt = rnd;
    rnd = lfsr(rnd);
    apb(1'b1, tmg_pkg::ADDR_COUNT_HIGH, rnd);
    m_cnt += rnd * 256;
    tk(5);
    rdc(cnt);
    `CHK("count_off", m_cnt[15:0], cnt)
    apb(1'b1, tmg_pkg::ADDR_TIMER_CONTROL, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      far_u.set_pin(i[0]);
      wgc({i[2], i[1], 6'h00});
      clr_cnt();
      rnd = lfsr(rnd);
      tk(int'(rnd[2:0]) + 1);
      m_cnt = (!i[2] || i[0] == i[1]) ? int'(rnd[2:0]) + 1 : 0;
      rdc(cnt);
      `CHK("count_gate", m_cnt[15:0], cnt)
      rgc("gate_value", {i[2], i[1], 3'h0, i[0] == i[1], 2'h0});
    end
    // Overflow source: the one-cycle pulse falls and raises the event.
    wgc(8'h41);
    apb(1'b1, tmg_pkg::ADDR_IRQ_MASK, 8'h00);
    apb(1'b0, tmg_pkg::ADDR_IRQ_STATUS, 8'h00);
    far_u.burst(255);
    rd("companion", tmg_pkg::ADDR_COMPANION, 9'h0ff);
    rd("no_event", tmg_pkg::ADDR_IRQ_STATUS, 9'h000);
    far_u.burst(1);
    repeat (6) @(posedge i_clock);
    `CHK("irq_masked", 1'b0, o_irq)
    apb(1'b1, tmg_pkg::ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge i_clock);
    `CHK("irq_on", 1'b1, o_irq)
    rd("event", tmg_pkg::ADDR_IRQ_STATUS, 9'h001);
    repeat (2) @(posedge i_clock);
    `CHK("irq_off", 1'b0, o_irq)
    // Toggle mode: each rising pin edge flips the gate.
    far_u.set_pin(1'b0);
    wgc(8'he0);
    m_tog = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      far_u.pulse(3);
      m_tog = ~m_tog;
      rgc("toggle", {5'h1c, m_tog, 2'h0});
    end
    wgc(8'hc0);
    wgc(8'he0);
    rgc("toggle_clr", 8'he0);
    far_u.pulse(3);
    rgc("toggle_set", 8'he4);
    apb(1'b1, tmg_pkg::ADDR_TIMER_CONTROL, 8'h00);
    rgc("timer_off", 8'he0);
    // Single pulse: only the first armed pulse counts.
    apb(1'b1, tmg_pkg::ADDR_TIMER_CONTROL, 8'h01);
    wgc(8'hd0);
    clr_cnt();
    apb(1'b0, tmg_pkg::ADDR_IRQ_STATUS, 8'h00);
    wgc(8'hd8);
    rgc("armed", 8'hd8);
    for (int i = 0; i < 2; i++)
    begin
      far_u.set_pin(1'b1);
      repeat (3) @(posedge i_clock);
      tk(4);
      far_u.set_pin(1'b0);
      repeat (4) @(posedge i_clock);
      rgc("go_done", 8'hd0);
    end
    rdc(cnt);
    `CHK("single", 16'h0004, cnt)
    rd("gate_event", tmg_pkg::ADDR_IRQ_STATUS, 9'h001);
    // Reserved source is a constant low, so active-low polarity shows one.
    wgc(8'h02);
    rgc("reserved", 8'h06);
    // Ungated count wraps from all ones and flags the rollover.
    wgc(8'h00);
    apb(1'b1, tmg_pkg::ADDR_COUNT_LOW, 8'hff);
    apb(1'b1, tmg_pkg::ADDR_COUNT_HIGH, 8'hff);
    tk(1);
    rd("rollover", tmg_pkg::ADDR_IRQ_STATUS, 9'h002);
    rdc(cnt);
    `CHK("wrap", 16'h0000, cnt)
    stop_test();
  end
endmodule : test_timer_gate_control
